/* ptc_pkg.sv */
// Summary of operation
// - Three masks pick inputs that reset controller, integral part, output fading.
// - Mask bits 0..7 pick enable/reset, reset, forward, reverse, inputs one-four.
// - Mask bits 8..11 pick internal inputs A to D, no terminal.
// - Fade reset ramps the fade factor over the fading time; a fading time of 0 switches it at once.
// - Fade factor counts down while fade reset input active, up otherwise.
// - Controller output percent becomes frequency; 100% equals set full-scale frequency.
// - Mode bits 1:0 equal 1 adds controller frequency to ramp output.
// - Setpoint is absolute setpoint plus selected extra reference.
// - Extra reference codes: 0 off, 1 and 2 analog two, 3 reserved, 4 aux.
// - Absolute setpoint limited to +-400.0 percent, one value per parameter set.
// - Feedback codes: 0 analog one, 1 analog two, 2 reserved, 3 aux, 4 digital.
// - Feedback code 5 uses active current, rated current is 100 percent.
// - Feedback code 6 uses utilization times ten, 0 to 255 percent.
// - Feedback code 7 uses DC-link voltage, 1000 V is 100 percent.
// - Feedback code 8 uses active power, twice rated value is 100 percent.
//
package ptc_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned FADE_TICK_US = 1000;
  localparam int unsigned FADE_TICK_CYCLES = CLK_HZ / 1_000_000 * FADE_TICK_US;
  // Fading time counts 10 ms units, fade runs 1000 steps per full swing
  localparam logic [31:0] FADE_ACC_ADD = 32'h00000064;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_FULL_MASK = 8'h00;
  localparam logic [7:0] ADDR_INT_MASK = 8'h04;
  localparam logic [7:0] ADDR_FADE_MASK = 8'h08;
  localparam logic [7:0] ADDR_FULL_SCALE = 8'h0c;
  localparam logic [7:0] ADDR_EXTRA_SEL = 8'h10;
  localparam logic [7:0] ADDR_ABS_SETPOINT = 8'h14;
  localparam logic [7:0] ADDR_FEEDBACK_SEL = 8'h18;
  localparam logic [7:0] ADDR_DIG_FEEDBACK = 8'h1c;
  localparam logic [7:0] ADDR_FADING_TIME = 8'h20;
  localparam logic [7:0] ADDR_SPEED_CFG = 8'h24;
  localparam logic [7:0] ADDR_INTERNAL_IN = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;
  localparam logic [7:0] ADDR_SET_POINTER = 8'h30;
  localparam logic [7:0] ADDR_OUT_FREQ = 8'h34;
  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [11:0] MASK_RST = 12'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] PCT_MAX = 16'h0fa0;
  localparam logic [15:0] PCT_MIN = 16'hf060;
  localparam logic [15:0] FADE_FULL = 16'h03e8;
  localparam logic [32:0] SCALE_DIV = 33'h0000003e8;
  // ****************************************
  // Selector codes
  // ****************************************
  localparam logic [15:0] EXTRA_OFF = 16'h0000;
  localparam logic [15:0] EXTRA_AN2_A = 16'h0001;
  localparam logic [15:0] EXTRA_AN2_B = 16'h0002;
  localparam logic [15:0] EXTRA_AUX = 16'h0004;
  localparam logic [15:0] FB_AN1 = 16'h0000;
  localparam logic [15:0] FB_AN2 = 16'h0001;
  localparam logic [15:0] FB_AUX = 16'h0003;
  localparam logic [15:0] FB_DIGITAL = 16'h0004;
  localparam logic [15:0] FB_CURRENT = 16'h0005;
  localparam logic [15:0] FB_UTIL = 16'h0006;
  localparam logic [15:0] FB_DCLINK = 16'h0007;
  localparam logic [15:0] FB_POWER = 16'h0008;
  localparam logic [1:0] MODE_ADD = 2'h1;
endpackage : ptc_pkg

/* ptc_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module ptc_controller #(
  parameter int unsigned FADE_TICK_CYCLES = ptc_pkg::FADE_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic [7:0] terminalInputs,
  input wire logic [2:0] paramSet,
  input wire logic signed [15:0] pidOutputPct,
  input wire logic signed [15:0] rampOutputFrequency,
  input wire logic signed [15:0] analogInOneValue,
  input wire logic signed [15:0] analogInTwoValue,
  input wire logic signed [15:0] auxInputValue,
  input wire logic signed [15:0] activeCurrentValue,
  input wire logic [7:0] utilizationValue,
  input wire logic [15:0] dcLinkVoltageValue,
  input wire logic signed [15:0] activePowerValue,
  output logic signed [15:0] outputFrequency,
  output logic signed [15:0] pidSetpoint,
  output logic signed [15:0] pidFeedback,
  output logic pidFullReset,
  output logic pidIntegralReset,
  output logic [15:0] fadeFactor
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic maskHit(input logic [11:0] mask, input logic [11:0] inputs);
    maskHit = |(mask & inputs);
  endfunction : maskHit

  function automatic logic [15:0] clampPct(input logic [15:0] v);
    if ($signed(v) > $signed(ptc_pkg::PCT_MAX)) begin
      clampPct = ptc_pkg::PCT_MAX;
    end else if ($signed(v) < $signed(ptc_pkg::PCT_MIN)) begin
      clampPct = ptc_pkg::PCT_MIN;
    end else begin
      clampPct = v;
    end
  endfunction : clampPct

  function automatic logic [15:0] laneWrite(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
    laneWrite = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : laneWrite

  // ****************************************
  // Registers
  // ****************************************
  logic [11:0] fullMask_q, intMask_q, fadeMask_q;
  logic [15:0] fullScale_q, extraSel_q, feedbackSel_q, digFeedback_q;
  logic [15:0] fadingTime_q, speedCfg_q;
  logic [3:0] internalIn_q;
  logic [2:0] setPointer_q;
  logic [15:0] absSetpoint_q [8];
  logic [15:0] fade_q;
  logic [31:0] fadeAcc_q;
  logic [31:0] tickCnt_q;
  logic tick_q;
  logic fadeActive;
  logic [11:0] allInputs;
  logic wbWrite;
  logic [31:0] readData;

  assign allInputs = {internalIn_q, terminalInputs};
  assign wbWrite = wbCyc && wbStb && wbWe && !wbAck;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fullMask_q <= ptc_pkg::MASK_RST;
      intMask_q <= ptc_pkg::MASK_RST;
      fadeMask_q <= ptc_pkg::MASK_RST;
      fullScale_q <= ptc_pkg::WORD_RST;
      extraSel_q <= ptc_pkg::EXTRA_OFF;
      feedbackSel_q <= ptc_pkg::WORD_RST;
      digFeedback_q <= ptc_pkg::WORD_RST;
      fadingTime_q <= ptc_pkg::WORD_RST;
      speedCfg_q <= ptc_pkg::WORD_RST;
      internalIn_q <= 4'h0;
      setPointer_q <= 3'h0;
    end else if (wbWrite) begin
      unique case (wbAdr)
        ptc_pkg::ADDR_FULL_MASK: fullMask_q <= 12'(laneWrite({4'h0, fullMask_q}, wbDatI, wbSel));
        ptc_pkg::ADDR_INT_MASK: intMask_q <= 12'(laneWrite({4'h0, intMask_q}, wbDatI, wbSel));
        ptc_pkg::ADDR_FADE_MASK: fadeMask_q <= 12'(laneWrite({4'h0, fadeMask_q}, wbDatI, wbSel));
        ptc_pkg::ADDR_FULL_SCALE: fullScale_q <= clampPct(laneWrite(fullScale_q, wbDatI, wbSel));
        ptc_pkg::ADDR_EXTRA_SEL: extraSel_q <= laneWrite(extraSel_q, wbDatI, wbSel);
        ptc_pkg::ADDR_FEEDBACK_SEL: feedbackSel_q <= laneWrite(feedbackSel_q, wbDatI, wbSel);
        ptc_pkg::ADDR_DIG_FEEDBACK:
          digFeedback_q <= clampPct(laneWrite(digFeedback_q, wbDatI, wbSel));
        ptc_pkg::ADDR_FADING_TIME: fadingTime_q <= laneWrite(fadingTime_q, wbDatI, wbSel);
        ptc_pkg::ADDR_SPEED_CFG: speedCfg_q <= laneWrite(speedCfg_q, wbDatI, wbSel);
        ptc_pkg::ADDR_INTERNAL_IN: internalIn_q <= sel0(wbSel) ? wbDatI[3:0] : internalIn_q;
        ptc_pkg::ADDR_SET_POINTER: setPointer_q <= sel0(wbSel) ? wbDatI[2:0] : setPointer_q;
        default: ;
      endcase
    end
  end

  function automatic logic sel0(input logic [3:0] sel);
    sel0 = sel[0];
  endfunction : sel0

  // One stored setpoint per parameter set, reached through the set pointer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        absSetpoint_q[i] <= ptc_pkg::WORD_RST;
      end
    end else if (wbWrite && wbAdr == ptc_pkg::ADDR_ABS_SETPOINT) begin
      absSetpoint_q[setPointer_q] <=
        clampPct(laneWrite(absSetpoint_q[setPointer_q], wbDatI, wbSel));
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  always_comb begin
    unique case (wbAdr)
      ptc_pkg::ADDR_FULL_MASK: readData = {20'h0, fullMask_q};
      ptc_pkg::ADDR_INT_MASK: readData = {20'h0, intMask_q};
      ptc_pkg::ADDR_FADE_MASK: readData = {20'h0, fadeMask_q};
      ptc_pkg::ADDR_FULL_SCALE: readData = {16'h0, fullScale_q};
      ptc_pkg::ADDR_EXTRA_SEL: readData = {16'h0, extraSel_q};
      ptc_pkg::ADDR_ABS_SETPOINT: readData = {16'h0, absSetpoint_q[setPointer_q]};
      ptc_pkg::ADDR_FEEDBACK_SEL: readData = {16'h0, feedbackSel_q};
      ptc_pkg::ADDR_DIG_FEEDBACK: readData = {16'h0, digFeedback_q};
      ptc_pkg::ADDR_FADING_TIME: readData = {16'h0, fadingTime_q};
      ptc_pkg::ADDR_SPEED_CFG: readData = {16'h0, speedCfg_q};
      ptc_pkg::ADDR_INTERNAL_IN: readData = {28'h0, internalIn_q};
      ptc_pkg::ADDR_STATUS: readData = {fade_q, 13'h0, fadeActive, pidIntegralReset, pidFullReset};
      ptc_pkg::ADDR_SET_POINTER: readData = {29'h0, setPointer_q};
      ptc_pkg::ADDR_OUT_FREQ: readData = {16'h0, outputFrequency};
      default: readData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h00000000;
    end else begin
      wbAck <= wbCyc && wbStb && !wbAck;
      wbDatO <= (wbCyc && wbStb && !wbWe && !wbAck) ? readData : 32'h00000000;
    end
  end

  // ****************************************
  // Reset selection
  // ****************************************
  assign fadeActive = maskHit(fadeMask_q, allInputs);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pidFullReset <= 1'b0;
      pidIntegralReset <= 1'b0;
    end else begin
      pidFullReset <= maskHit(fullMask_q, allInputs);
      pidIntegralReset <= maskHit(intMask_q, allInputs);
    end
  end

  // ****************************************
  // Fade ramp
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tickCnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tickCnt_q >= FADE_TICK_CYCLES - 1) begin
      tickCnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // Fractional accumulator; one step per clock keeps short fading times exact
  logic fadeAtLimit, fadeStep;
  assign fadeAtLimit = fadeActive ? (fade_q == 16'h0000) : (fade_q == ptc_pkg::FADE_FULL);
  assign fadeStep = fadeAcc_q >= {16'h0, fadingTime_q};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fade_q <= ptc_pkg::FADE_FULL;
      fadeAcc_q <= 32'h00000000;
    end else if (fadingTime_q == 16'h0000) begin
      fade_q <= fadeActive ? 16'h0000 : ptc_pkg::FADE_FULL;
      fadeAcc_q <= 32'h00000000;
    end else if (fadeAtLimit) begin
      fadeAcc_q <= 32'h00000000;
    end else if (fadeStep) begin
      fade_q <= fadeActive ? fade_q - 16'h0001 : fade_q + 16'h0001;
      // A tick landing on a step is still banked, or long swings would run slow
      fadeAcc_q <= fadeAcc_q - {16'h0, fadingTime_q}
                   + (tick_q ? ptc_pkg::FADE_ACC_ADD : 32'h00000000);
    end else if (tick_q) begin
      fadeAcc_q <= fadeAcc_q + ptc_pkg::FADE_ACC_ADD;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fadeFactor <= ptc_pkg::FADE_FULL;
    end else begin
      fadeFactor <= fade_q;
    end
  end

  // ****************************************
  // Output frequency
  // ****************************************
  logic signed [32:0] fadedProd, fadedPct, freqProd, freqVal;
  logic signed [15:0] controlPct;
  assign controlPct = pidFullReset ? 16'sh0000 : pidOutputPct;
  assign fadedProd = $signed({{17{controlPct[15]}}, controlPct}) * $signed({17'h0, fade_q});
  assign fadedPct = fadedProd / $signed(ptc_pkg::SCALE_DIV);
  assign freqProd = $signed({{17{fadedPct[15]}}, fadedPct[15:0]})
                    * $signed({{17{fullScale_q[15]}}, fullScale_q});
  assign freqVal = freqProd / $signed(ptc_pkg::SCALE_DIV);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      outputFrequency <= 16'sh0000;
    end else if (speedCfg_q[1:0] == ptc_pkg::MODE_ADD) begin
      outputFrequency <= rampOutputFrequency + freqVal[15:0];
    end else begin
      outputFrequency <= rampOutputFrequency;
    end
  end

  // ****************************************
  // Setpoint and feedback
  // ****************************************
  logic signed [15:0] extraRef, feedbackSel;
  always_comb begin
    unique case (extraSel_q)
      ptc_pkg::EXTRA_AN2_A, ptc_pkg::EXTRA_AN2_B: extraRef = analogInTwoValue;
      ptc_pkg::EXTRA_AUX: extraRef = auxInputValue;
      default: extraRef = 16'sh0000;
    endcase
  end

  always_comb begin
    unique case (feedbackSel_q)
      ptc_pkg::FB_AN1: feedbackSel = analogInOneValue;
      ptc_pkg::FB_AN2: feedbackSel = analogInTwoValue;
      ptc_pkg::FB_AUX: feedbackSel = auxInputValue;
      ptc_pkg::FB_DIGITAL: feedbackSel = digFeedback_q;
      ptc_pkg::FB_CURRENT: feedbackSel = activeCurrentValue;
      ptc_pkg::FB_UTIL: feedbackSel = 16'({8'h0, utilizationValue} * 16'h000a);
      ptc_pkg::FB_DCLINK: feedbackSel = dcLinkVoltageValue;
      ptc_pkg::FB_POWER: feedbackSel = activePowerValue >>> 1;
      default: feedbackSel = 16'sh0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pidSetpoint <= 16'sh0000;
      pidFeedback <= 16'sh0000;
    end else begin
      pidSetpoint <= $signed(absSetpoint_q[paramSet]) + extraRef;
      pidFeedback <= feedbackSel;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Each check but chk_read_idle looks one edge on, since the outputs they watch are registered
  chk_full_reset: assert property (
    maskHit(fullMask_q, allInputs) |=> pidFullReset)
    else $error("full reset not raised");
  chk_int_reset: assert property (
    !maskHit(intMask_q, allInputs) |=> !pidIntegralReset)
    else $error("integral reset without input");
  chk_terminal_bit: assert property (
    fullMask_q == 12'h001 && terminalInputs == 8'h01 |=> pidFullReset)
    else $error("terminal bit 0 not mapped");
  chk_internal_bit: assert property (
    intMask_q == 12'h100 && internalIn_q == 4'h1 && terminalInputs == 8'h00
    |=> pidIntegralReset)
    else $error("internal input A not mapped");
  chk_fade_gradual: assert property (
    fadingTime_q != 16'h0000 && $stable(fadingTime_q)
    |=> (fade_q == $past(fade_q) || fade_q == $past(fade_q) + 16'h0001
    || fade_q == $past(fade_q) - 16'h0001))
    else $error("fade factor jumped");
  chk_fade_zero_time: assert property (
    fadingTime_q == 16'h0000 && fadeActive |=> fade_q == 16'h0000)
    else $error("fade did not drop with zero time");
  chk_fade_down: assert property (
    fadeActive && fadingTime_q != 16'h0000 && fadeStep && !fadeAtLimit
    |=> fade_q == $past(fade_q) - 16'h0001)
    else $error("fade factor did not count down");
  chk_fade_up: assert property (
    !fadeActive && fadingTime_q != 16'h0000 && fadeStep && !fadeAtLimit
    |=> fade_q == $past(fade_q) + 16'h0001)
    else $error("fade factor did not count up");
  chk_freq_reset: assert property (
    pidFullReset && speedCfg_q[1:0] == ptc_pkg::MODE_ADD
    |=> outputFrequency == $past(rampOutputFrequency))
    else $error("controller frequency added during full reset");
  chk_mode_add: assert property (
    speedCfg_q[1:0] != ptc_pkg::MODE_ADD |=> outputFrequency == $past(rampOutputFrequency))
    else $error("controller added outside add mode");
  chk_extra_off: assert property (
    extraSel_q == ptc_pkg::EXTRA_OFF
    |=> pidSetpoint == $signed($past(absSetpoint_q[paramSet])))
    else $error("extra reference not off");
  chk_extra_aux: assert property (
    extraSel_q == ptc_pkg::EXTRA_AUX
    |=> pidSetpoint == $signed($past(absSetpoint_q[paramSet])) + $past(auxInputValue))
    else $error("aux reference not added");
  chk_feedback_an2: assert property (
    feedbackSel_q == ptc_pkg::FB_AN2 |=> pidFeedback == $past(analogInTwoValue))
    else $error("analog two feedback wrong");
  chk_current_fb: assert property (
    feedbackSel_q == ptc_pkg::FB_CURRENT |=> pidFeedback == $past(activeCurrentValue))
    else $error("active current feedback wrong");
  chk_util_fb: assert property (
    feedbackSel_q == ptc_pkg::FB_UTIL
    |=> pidFeedback == $signed({8'h00, $past(utilizationValue)} * 16'h000a))
    else $error("utilization feedback wrong");
  chk_dclink_fb: assert property (
    feedbackSel_q == ptc_pkg::FB_DCLINK |=> pidFeedback == $signed($past(dcLinkVoltageValue)))
    else $error("DC-link feedback wrong");
  chk_power_fb: assert property (
    feedbackSel_q == ptc_pkg::FB_POWER |=> pidFeedback == ($past(activePowerValue) >>> 1))
    else $error("active power feedback wrong");
  chk_reserved_fb: assert property (
    feedbackSel_q == 16'h0002 |=> pidFeedback == 16'sh0000)
    else $error("reserved feedback code not zero");
  chk_ack_single: assert property (wbAck |=> !wbAck)
    else $error("bus ack held over two cycles");
  chk_read_idle: assert property (!wbAck |-> wbDatO == 32'h00000000)
    else $error("read data without ack");
endmodule : ptc_controller
`default_nettype wire

/* ptc_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Drive side: terminals, measured values, ramp path
// ****************************************
module ptc_drive_model (
  input wire logic clk,
  input wire logic [7:0] termReq,
  output logic [7:0] terminalInputs,
  output logic signed [15:0] rampOutputFrequency,
  output logic signed [15:0] analogInOneValue,
  output logic signed [15:0] analogInTwoValue,
  output logic signed [15:0] auxInputValue,
  output logic signed [15:0] activeCurrentValue,
  output logic [7:0] utilizationValue,
  output logic [15:0] dcLinkVoltageValue,
  output logic signed [15:0] activePowerValue
);
  // Terminals settle one edge late, like a filtered input stage
  always_ff @(posedge clk) begin
    terminalInputs <= termReq;
  end
  // Distinct values so a wrong selector never matches by luck
  assign rampOutputFrequency = 16'sh00c8;
  assign analogInOneValue = 16'sh006f;
  assign analogInTwoValue = 16'sh00de;
  assign auxInputValue = 16'sh014d;
  assign activeCurrentValue = 16'sh01bc;
  assign utilizationValue = 8'h37;
  assign dcLinkVoltageValue = 16'h029a;
  assign activePowerValue = 16'sh0320;
endmodule : ptc_drive_model
`default_nettype wire

/* ptc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h3;
  logic [31:0] wbDatI = 32'h00000000;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [7:0] termReq = 8'h00;
  logic [7:0] terminalInputs, utilizationValue;
  logic [2:0] paramSet = 3'h0;
  logic signed [15:0] pidOutputPct = 16'sh03e8;
  logic signed [15:0] rampOutputFrequency, analogInOneValue, analogInTwoValue, auxInputValue;
  logic signed [15:0] activeCurrentValue, activePowerValue, outputFrequency, pidSetpoint;
  logic signed [15:0] pidFeedback;
  logic [15:0] dcLinkVoltageValue, fadeFactor;
  logic pidFullReset, pidIntegralReset;
  logic [31:0] rd;
  int failures = 0;
  int n_compared = 0;
  int k;
  always #20 clk = ~clk;
  ptc_drive_model model (.clk(clk), .termReq(termReq), .terminalInputs(terminalInputs),
    .rampOutputFrequency(rampOutputFrequency), .analogInOneValue(analogInOneValue),
    .analogInTwoValue(analogInTwoValue), .auxInputValue(auxInputValue),
    .activeCurrentValue(activeCurrentValue), .utilizationValue(utilizationValue),
    .dcLinkVoltageValue(dcLinkVoltageValue), .activePowerValue(activePowerValue));
  ptc_controller #(.FADE_TICK_CYCLES(10)) DUT (.clk(clk), .resetn(resetn), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .terminalInputs(terminalInputs), .paramSet(paramSet),
    .pidOutputPct(pidOutputPct), .rampOutputFrequency(rampOutputFrequency),
    .analogInOneValue(analogInOneValue), .analogInTwoValue(analogInTwoValue),
    .auxInputValue(auxInputValue), .activeCurrentValue(activeCurrentValue),
    .utilizationValue(utilizationValue), .dcLinkVoltageValue(dcLinkVoltageValue),
    .activePowerValue(activePowerValue), .outputFrequency(outputFrequency),
    .pidSetpoint(pidSetpoint), .pidFeedback(pidFeedback), .pidFullReset(pidFullReset),
    .pidIntegralReset(pidIntegralReset), .fadeFactor(fadeFactor));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run();
    $display("counts: compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    n_compared++;
    if (got !== expv) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask : chk
  // Ack is sampled before the edge's own updates land, as the bus expects
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("bus ack", 32'h1, 32'h0);
    end
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb
  // Terminals pass the model's register, so outputs lag a few edges
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_regs();
    chk("fade after reset", 32'h3e8, {16'h0, fadeFactor});
    wb(1'b0, ptc_pkg::ADDR_EXTRA_SEL, 32'h0);
    chk("extra select reset", 32'h0, rd);
    wb(1'b0, ptc_pkg::ADDR_FULL_MASK, 32'h0);
    chk("full mask reset", 32'h0, rd);
    wb(1'b1, 8'hfc, 32'h1234);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("test reset_regs done");
  endtask : t_reset_regs
  task automatic t_masks();
    for (k = 0; k < 8; k++) begin
      wb(1'b1, ptc_pkg::ADDR_FULL_MASK, 32'h1 << k);
      wb(1'b0, ptc_pkg::ADDR_FULL_MASK, 32'h0);
      chk("full mask rw", 32'h1 << k, rd);
      termReq <= 8'h1 << k;
      settle();
      chk("full reset on", 32'h1, {31'h0, pidFullReset});
      termReq <= ~(8'h1 << k);
      settle();
      chk("full reset off", 32'h0, {31'h0, pidFullReset});
    end
    termReq <= 8'h00;
    for (k = 0; k < 4; k++) begin
      wb(1'b1, ptc_pkg::ADDR_INT_MASK, 32'h100 << k);
      wb(1'b1, ptc_pkg::ADDR_INTERNAL_IN, 32'h1 << k);
      settle();
      chk("integral by internal", 32'h1, {31'h0, pidIntegralReset});
      chk("full stays off", 32'h0, {31'h0, pidFullReset});
      wb(1'b1, ptc_pkg::ADDR_INTERNAL_IN, 32'hf & ~(32'h1 << k));
      settle();
      chk("integral off", 32'h0, {31'h0, pidIntegralReset});
    end
    wb(1'b1, ptc_pkg::ADDR_INTERNAL_IN, 32'h0);
    $display("test masks done");
  endtask : t_masks
  task automatic t_feedback();
    logic [15:0] expv [10];
    expv = '{16'h006f, 16'h00de, 16'h0, 16'h014d, 16'h007b, 16'h01bc, 16'h0226, 16'h029a,
      16'h0190, 16'h0};
    wb(1'b1, ptc_pkg::ADDR_DIG_FEEDBACK, 32'h7b);
    for (k = 0; k < 10; k++) begin
      wb(1'b1, ptc_pkg::ADDR_FEEDBACK_SEL, k);
      settle();
      chk("feedback by code", {16'h0, expv[k]}, {16'h0, pidFeedback});
    end
    $display("test feedback done");
  endtask : t_feedback
  task automatic t_setpoint();
    logic [15:0] expv [6];
    expv = '{16'h0064, 16'h0142, 16'h0142, 16'h0064, 16'h01b1, 16'h0064};
    wb(1'b1, ptc_pkg::ADDR_ABS_SETPOINT, 32'h64);
    for (k = 0; k < 6; k++) begin
      wb(1'b1, ptc_pkg::ADDR_EXTRA_SEL, k);
      settle();
      chk("setpoint by code", {16'h0, expv[k]}, {16'h0, pidSetpoint});
    end
    wb(1'b1, ptc_pkg::ADDR_EXTRA_SEL, 32'h0);
    wb(1'b1, ptc_pkg::ADDR_ABS_SETPOINT, 32'h1000);
    wb(1'b1, ptc_pkg::ADDR_SET_POINTER, 32'h1);
    wb(1'b1, ptc_pkg::ADDR_ABS_SETPOINT, 32'h32);
    settle();
    chk("setpoint clamp", {16'h0, ptc_pkg::PCT_MAX}, {16'h0, pidSetpoint});
    paramSet <= 3'h1;
    settle();
    chk("setpoint set one", 32'h32, {16'h0, pidSetpoint});
    $display("test setpoint done");
  endtask : t_setpoint
  task automatic t_frequency();
    wb(1'b1, ptc_pkg::ADDR_FULL_SCALE, 32'h1f4);
    settle();
    chk("ramp only", 32'hc8, {16'h0, outputFrequency});
    wb(1'b1, ptc_pkg::ADDR_SPEED_CFG, {30'h0, ptc_pkg::MODE_ADD});
    settle();
    chk("ramp plus full", 32'h2bc, {16'h0, outputFrequency});
    pidOutputPct <= -16'sd500;
    settle();
    chk("ramp minus half", 32'hffce, {16'h0, outputFrequency});
    termReq <= 8'h80;
    settle();
    chk("freq in full reset", 32'hc8, {16'h0, outputFrequency});
    termReq <= 8'h00;
    $display("test frequency done");
  endtask : t_frequency
  task automatic t_fade();
    int n;
    wb(1'b1, ptc_pkg::ADDR_FADE_MASK, 32'h1);
    wb(1'b1, ptc_pkg::ADDR_FADING_TIME, 32'h1);
    termReq <= 8'h01;
    settle();
    chk("fade not abrupt", 32'h1, {31'h0, fadeFactor != 16'h0});
    n = 0;
    while (fadeFactor !== 16'h0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk("fade down gradual", 32'h1, {31'h0, n > 100 && n < 20000});
    chk("freq without pid", 32'hc8, {16'h0, outputFrequency});
    termReq <= 8'h00;
    n = 0;
    while (fadeFactor !== 16'h3e8 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk("fade up gradual", 32'h1, {31'h0, n > 100 && n < 20000});
    wb(1'b1, ptc_pkg::ADDR_FADING_TIME, 32'h0);
    termReq <= 8'h01;
    settle();
    chk("fade jump", 32'h0, {16'h0, fadeFactor});
    $display("test fade done");
  endtask : t_fade
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset_regs();
    t_masks();
    t_feedback();
    t_setpoint();
    t_frequency();
    t_fade();
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
